// ---- rtl/rfsf_pkg.sv ----
package rfsf_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_DATA  = 10'h008;
    localparam logic [9:0] IDX_FLAGS = 10'h009;
    localparam logic [9:0] IDX_CTRL  = 10'h00A;
    localparam logic [9:0] IDX_CNTL  = 10'h00B;
    localparam logic [9:0] IDX_CNTH  = 10'h00C;
    localparam logic [9:0] IDX_DSCNT = 10'h00D;
    localparam logic [9:0] IDX_ISTAT = 10'h00E;
    localparam logic [9:0] IDX_IMASK = 10'h00F;

    // Receive flag register fields and reset value
    localparam int FLG_OVF  = 0;
    localparam int FLG_URF  = 1;
    localparam int FLG_FULL = 2;
    localparam int FLG_EMP  = 3;
    localparam logic [7:0] FLAGS_RST = 8'h08;

    // Control register fields and reset value
    localparam int CTL_CLR = 0;
    localparam int CTL_FRC = 1;
    localparam int CTL_ISO = 2;
    localparam int CTL_SZ  = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Interrupt status and mask fields
    localparam int INT_URF = 0;
    localparam int INT_OVF = 1;
    localparam int INT_SET = 2;
    localparam int INT_W   = 3;
    localparam logic [2:0] INT_RST = 3'h0;

    // Storage geometry
    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int LVL_W = 7;
    localparam int CNT_W = 10;

    // Data-set count limits
    localparam logic [1:0] DSC_ZERO = 2'h0;
    localparam logic [1:0] DSC_MAX  = 2'h3;
    localparam logic [9:0] CNT_RST  = 10'h000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Configured size in bytes from the size code
    function automatic logic [LVL_W-1:0] fifo_size(input logic [1:0] code);
        logic [LVL_W-1:0] s;
        s = 7'h08;
        unique case (code)
            2'h0: s = 7'h08;
            2'h1: s = 7'h10;
            2'h2: s = 7'h20;
            2'h3: s = 7'h40;
        endcase
        return s;
    endfunction

endpackage

// ---- rtl/rfsf_fifo_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface rfsf_fifo_if;
    import rfsf_pkg::*;
    logic                  wr_en;
    logic [7:0]            wr_data;
    logic                  rd_en;
    logic                  clear;
    logic [1:0]            size_code;
    logic [7:0]            rd_data;
    logic                  full;
    logic                  empty;
    logic [LVL_W-1:0]      level;

    modport ctrl  (output wr_en, wr_data, rd_en, clear, size_code,
                   input  rd_data, full, empty, level);
    modport store (input  wr_en, wr_data, rd_en, clear, size_code,
                   output rd_data, full, empty, level);
endinterface
`default_nettype wire

// ---- rtl/rfsf_store.sv ----
`timescale 1ns/100ps
`default_nettype none
module rfsf_store (
    input wire logic   clk_in,  // Device clock
    input wire logic   rst_in,  // Async reset, active high
    rfsf_fifo_if.store fif      // Storage side of the FIFO
);
    import rfsf_pkg::*;

    logic [7:0]       mem [DEPTH];
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [LVL_W-1:0] level;
    logic [PTR_W-1:0] next_wptr;
    logic [PTR_W-1:0] next_rptr;
    logic [LVL_W-1:0] next_level;
    logic             do_wr;
    logic             do_rd;

    // Live flags straight from the level
    assign fif.level   = level;
    assign fif.full    = (level >= fifo_size(fif.size_code));
    assign fif.empty   = (level == '0);
    assign fif.rd_data = mem[rptr];

    // Pointers hold at the limits instead of wrapping into bad data
    always_comb begin
        do_wr = fif.wr_en && !fif.full;
        do_rd = fif.rd_en && !fif.empty;
        next_wptr  = wptr;
        next_rptr  = rptr;
        next_level = level;
        if (fif.clear) begin
            next_wptr  = '0;
            next_rptr  = '0;
            next_level = '0;
        end else begin
            if (do_wr) begin
                next_wptr = wptr + PTR_W'(1);
            end
            if (do_rd) begin
                next_rptr = rptr + PTR_W'(1);
            end
            if (do_wr && !do_rd) begin
                next_level = level + LVL_W'(1);
            end else if (do_rd && !do_wr) begin
                next_level = level - LVL_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            level <= next_level;
        end
    end

    // Data array needs no reset; contents unread until written
    always_ff @(posedge clk_in) begin
        if (do_wr && !fif.clear) begin
            mem[wptr] <= fif.wr_data;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/rfsf_top.sv ----
// Summary of operation
// - Full flag, bit 2, set when current data set reaches configured size.
// - Full flag follows live FIFO state in every mode.
// - Underrun, bit 1, set on empty data read or count read at zero sets.
// - Underrun stays set until firmware issues the FIFO clear.
// - Read pointer holds at empty on an underrun.
// - Endpoint is NAKed while underrun or overrun is set.
// - Isochronous: firmware changes act at once, USB changes at next SOF; here USB bytes and byte count land at once.
// - Isochronous underrun updates immediately.
// - Overrun, bit 0, set on write to full FIFO or count write at three.
// - Overrun cleared by FIFO clear, or by hardware on a later SETUP.
// - Isochronous overrun becomes visible only at next SOF.
// - Write pointer holds at full on an overrun.
// - Flag register at index 09H, resets to 0000 1000B.
// - Empty flag, bit 3, set when current data set holds no bytes.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rfsf_top (
    input  wire logic        clk_in,          // Device clock, 50 MHz
    input  wire logic        rst_in,          // Async reset, active high
    input  wire logic        psel_in,         // APB select
    input  wire logic        penable_in,      // APB enable
    input  wire logic        pwrite_in,       // APB direction, 1 = write
    input  wire logic [11:0] paddr_in,        // APB byte address
    input  wire logic [31:0] pwdata_in,       // APB write data
    output logic      [31:0] prdata_out,      // APB read data
    output logic             pready_out,      // APB ready
    output logic             pslverr_out,     // APB error, unmapped
    input  wire logic        se_wr_in,        // Engine writes one byte
    input  wire logic [7:0]  se_data_in,      // Engine byte
    input  wire logic        se_count_wr_in,  // Engine writes byte count
    input  wire logic [9:0]  se_count_in,     // Engine byte count
    input  wire logic        se_setup_in,     // SETUP packet received
    input  wire logic        sof_in,          // Start of frame pulse
    output logic             nak_out,         // NAK while underrun or overrun set
    output logic             irq_out          // Interrupt, active high
);
    import rfsf_pkg::*;

    // Byte storage; level, full and empty are live
    rfsf_fifo_if fif ();

    rfsf_store u_store (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .fif    (fif)
    );

    // Decode helper used by the error answer
    function automatic logic is_mapped(input logic [9:0] idx);
        return (idx >= IDX_DATA) && (idx <= IDX_IMASK);
    endfunction

    // Bus decode and strobes
    logic [9:0]       idx;
    logic             access;
    logic             done_rd;
    logic             done_wr;
    logic             clr_pulse;
    logic             frc_pulse;

    // APB answer flops
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;

    // Software-owned registers
    logic [7:0]       ctrl;
    logic [INT_W-1:0] imask;
    logic [7:0]       next_ctrl;
    logic [INT_W-1:0] next_imask;

    // Sticky flags, frame-deferred changes and counts
    logic             ovf;
    logic             urf;
    logic             pend_ovf;
    logic             pend_inc;
    logic [1:0]       dscnt;
    logic [CNT_W-1:0] bcount;
    logic [INT_W-1:0] istat;
    logic             nak;
    logic             irq;
    logic             next_ovf;
    logic             next_urf;
    logic             next_pend_ovf;
    logic             next_pend_inc;
    logic [1:0]       next_dscnt;
    logic [CNT_W-1:0] next_bcount;
    logic [INT_W-1:0] next_istat;
    logic             next_nak;
    logic             next_irq;

    // Event decode
    logic             iso;
    logic             ur_ev;
    logic             ov_ev;
    logic             ovf_set;
    logic             inc_ok;
    logic             inc_now;
    logic             dec_now;
    logic [7:0]       flags;

    // Bus phase decode; side effects land on the completing edge
    // Address bits 1:0 are ignored; each register is one word
    assign idx       = paddr_in[11:2];
    assign access    = psel_in && penable_in;
    assign done_rd   = access && pready && !pwrite_in;
    assign done_wr   = access && pready && pwrite_in;
    assign clr_pulse = done_wr && (idx == IDX_CTRL) && pwdata_in[CTL_CLR];
    assign frc_pulse = done_wr && (idx == IDX_CTRL) && pwdata_in[CTL_FRC];
    assign iso       = ctrl[CTL_ISO];

    // Live full and empty sit beside the sticky error bits
    // Full and empty are never latched, so they cannot go stale
    always_comb begin
        flags           = FLAGS_RST & 8'h00;
        flags[FLG_EMP]  = fif.empty;
        flags[FLG_FULL] = fif.full;
        flags[FLG_URF]  = urf;
        flags[FLG_OVF]  = ovf;
    end

    // FIFO hookup; the store holds its own pointers at the limits
    assign fif.wr_en     = se_wr_in;
    assign fif.wr_data   = se_data_in;
    assign fif.rd_en     = done_rd && (idx == IDX_DATA);
    assign fif.clear     = clr_pulse;
    assign fif.size_code = ctrl[CTL_SZ +: 2];

    // APB answer: one wait state so read data comes from a flop
    // Fixed latency costs a cycle per access but keeps timing easy
    // Unmapped indices answer with an error and read as zero
    always_comb begin
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !is_mapped(idx);
        next_prdata  = prdata;
        if (access && !pready) begin
            next_prdata = RDATA_RST;
            unique case (idx)
                IDX_DATA:  next_prdata[7:0] = fif.rd_data;
                IDX_FLAGS: next_prdata[7:0] = flags;
                IDX_CTRL:  next_prdata[7:0] = ctrl;
                IDX_CNTL:  next_prdata[7:0] = bcount[7:0];
                IDX_CNTH:  next_prdata[1:0] = bcount[9:8];
                IDX_DSCNT: next_prdata[1:0] = dscnt;
                IDX_ISTAT: next_prdata[INT_W-1:0] = istat;
                IDX_IMASK: next_prdata[INT_W-1:0] = imask;
                default:   next_prdata = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata  <= RDATA_RST;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Software control; clear and read-complete bits are strobes only
    // A size change acts at once; software should clear first
    always_comb begin
        next_ctrl  = ctrl;
        next_imask = imask;
        if (done_wr && (idx == IDX_CTRL)) begin
            next_ctrl = pwdata_in[7:0];
            next_ctrl[CTL_CLR] = 1'b0;
            next_ctrl[CTL_FRC] = 1'b0;
        end
        if (done_wr && (idx == IDX_IMASK)) begin
            next_imask = pwdata_in[INT_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl  <= CTRL_RST;
            imask <= INT_RST;
        end else begin
            ctrl  <= next_ctrl;
            imask <= next_imask;
        end
    end

    // Error events: underrun from firmware, overrun from the engine
    // Count reads with no data set pending also underrun
    assign ur_ev = done_rd && (((idx == IDX_DATA) && fif.empty) ||
                   (((idx == IDX_CNTL) || (idx == IDX_CNTH)) &&
                    (dscnt == DSC_ZERO)));
    assign ov_ev = (se_wr_in && fif.full) ||
                   (se_count_wr_in && (dscnt == DSC_MAX));
    // Isochronous overruns wait for the frame boundary
    assign ovf_set = iso ? (sof_in && pend_ovf) : ov_ev;
    assign inc_ok  = se_count_wr_in && (dscnt != DSC_MAX);
    assign inc_now = iso ? (sof_in && pend_inc) : inc_ok;
    assign dec_now = frc_pulse && (dscnt != DSC_ZERO);

    // Flag and count state; a flag set in the clearing cycle still lands, a set count increment does not
    always_comb begin
        next_urf      = urf;
        next_ovf      = ovf;
        next_pend_ovf = pend_ovf;
        next_pend_inc = pend_inc;
        next_dscnt    = dscnt;
        next_bcount   = bcount;
        next_istat    = istat;
        // Underrun only leaves through the clear strobe
        if (clr_pulse) begin
            next_urf = 1'b0;
        end
        if (ur_ev) begin
            next_urf = 1'b1;
        end
        // SETUP only clears an overrun that is already visible
        if (clr_pulse || (se_setup_in && ovf)) begin
            next_ovf = 1'b0;
        end
        if (ovf_set) begin
            next_ovf = 1'b1;
        end
        // Pending USB-side changes, drained at start of frame
        // An event in the frame-start cycle waits for the next frame
        if (iso) begin
            next_pend_ovf = (pend_ovf && !sof_in) || ov_ev;
            next_pend_inc = (pend_inc && !sof_in) || inc_ok;
        end else begin
            next_pend_ovf = 1'b0;
            next_pend_inc = 1'b0;
        end
        // Clear drops pending USB changes and empties the set count
        if (clr_pulse) begin
            next_pend_ovf = ov_ev && iso;
            next_pend_inc = 1'b0;
            next_dscnt    = DSC_ZERO;
        end else if (inc_now && !dec_now) begin
            next_dscnt = dscnt + 2'h1;
        end else if (dec_now && !inc_now) begin
            next_dscnt = dscnt - 2'h1;
        end
        // Byte count latches even when the set count is full
        if (se_count_wr_in) begin
            next_bcount = se_count_in;
        end
        // Sticky events; read clears, but a new event wins
        if (done_rd && (idx == IDX_ISTAT)) begin
            next_istat = INT_RST;
        end
        if (ur_ev && !urf) begin
            next_istat[INT_URF] = 1'b1;
        end
        if (ovf_set && !ovf) begin
            next_istat[INT_OVF] = 1'b1;
        end
        if (inc_now) begin
            next_istat[INT_SET] = 1'b1;
        end
        // NAK and interrupt use next values, so they move with the flags
        next_nak = next_urf || next_ovf;
        next_irq = |(next_istat & next_imask);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            // Only the empty flag reads set after reset
            urf      <= FLAGS_RST[FLG_URF];
            ovf      <= FLAGS_RST[FLG_OVF];
            pend_ovf <= 1'b0;
            pend_inc <= 1'b0;
            dscnt    <= DSC_ZERO;
            bcount   <= CNT_RST;
            istat    <= INT_RST;
            nak      <= 1'b0;
            irq      <= 1'b0;
        end else begin
            urf      <= next_urf;
            ovf      <= next_ovf;
            pend_ovf <= next_pend_ovf;
            pend_inc <= next_pend_inc;
            dscnt    <= next_dscnt;
            bcount   <= next_bcount;
            istat    <= next_istat;
            nak      <= next_nak;
            irq      <= next_irq;
        end
    end

    // Outputs straight from flops
    // No decode after the register, so outputs never glitch
    assign prdata_out  = prdata;
    assign pready_out  = pready;
    assign pslverr_out = pslverr;
    assign nak_out     = nak;
    assign irq_out     = irq;

endmodule
`default_nettype wire

// ---- verif/rfsf_engine_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Serial engine stand-in; every strobe lasts exactly one cycle
module rfsf_engine_model (
    output logic       wr_out,      // Byte strobe
    output logic [7:0] data_out,    // Byte
    output logic       cnt_wr_out,  // Count strobe
    output logic [9:0] cnt_out,     // Byte count
    output logic       setup_out,   // SETUP seen
    output logic       sof_out,     // Frame start
    input  wire logic  clk_in       // Device clock
);
    initial begin
        wr_out = 1'b0;
        data_out = 8'h00;
        cnt_wr_out = 1'b0;
        cnt_out = 10'h000;
        setup_out = 1'b0;
        sof_out = 1'b0;
    end

    // Released lines show the inverse, so a stale value never looks valid
    task automatic put_byte(input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        data_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        data_out <= ~d;
    endtask

    task automatic put_count(input logic [9:0] c);
        @(posedge clk_in);
        cnt_wr_out <= 1'b1;
        cnt_out <= c;
        @(posedge clk_in);
        cnt_wr_out <= 1'b0;
        cnt_out <= ~c;
    endtask

    // One-cycle SETUP or start-of-frame pulse
    task automatic strobe(input logic is_setup);
        @(posedge clk_in);
        setup_out <= is_setup;
        sof_out <= !is_setup;
        @(posedge clk_in);
        setup_out <= 1'b0;
        sof_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/rfsf_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module rfsf_checker
    import rfsf_pkg::*;
(
    input wire logic        clk_in,       // Device clock
    input wire logic        rst_in,       // Async reset
    input wire logic        psel_in,      // APB select
    input wire logic        penable_in,   // APB enable
    input wire logic        pwrite_in,    // APB direction
    input wire logic [11:0] paddr_in,     // APB address
    input wire logic [31:0] pwdata_in,    // APB write data
    input wire logic [31:0] prdata_out,   // APB read data
    input wire logic        pready_out,   // APB ready
    input wire logic        pslverr_out,  // APB error
    input wire logic        se_wr_in,     // Engine byte
    input wire logic        se_count_wr_in, // Engine count
    input wire logic        se_setup_in,  // SETUP
    input wire logic        sof_in,       // Frame start
    input wire logic        nak_out       // NAK level
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Completing flag read and completing clear write
    logic rd_flags;
    logic clr_done;
    assign rd_flags = pready_out && !pwrite_in && paddr_in[11:2] == IDX_FLAGS;
    assign clr_done = psel_in && penable_in && pready_out && pwrite_in
                      && paddr_in[11:2] == IDX_CTRL && pwdata_in[CTL_CLR];

    sequence s_wait;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_done;
        psel_in && penable_in && pready_out;
    endsequence

    a_one_wait_state: assert property (psel_in && !penable_in |=>
        s_wait ##1 s_done) else $error("APB answer not after one wait");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pslverr_out |-> pready_out &&
        (paddr_in[11:2] < IDX_DATA || paddr_in[11:2] > IDX_IMASK))
        else $error("pslverr on a mapped index");
    a_flags_upper_zero: assert property (
        rd_flags |-> prdata_out[31:4] == 28'h0)
        else $error("flag word upper bits set");
    a_error_flag_naks: assert property (
        rd_flags && |prdata_out[1:0] |-> nak_out || $past(se_setup_in))
        else $error("error flag set without nak");
    a_full_excl_empty: assert property (
        rd_flags |-> !(prdata_out[FLG_FULL] && prdata_out[FLG_EMP]))
        else $error("full and empty together");
    a_nak_sticky: assert property (
        nak_out && !se_setup_in && !clr_done |=> nak_out)
        else $error("nak dropped without clear");
    a_nak_has_cause: assert property (
        $rose(nak_out) |-> $past(se_wr_in || se_count_wr_in || sof_in
        || (pready_out && !pwrite_in))) else $error("nak rose uncaused");
endmodule

bind rfsf_top rfsf_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .se_wr_in(se_wr_in), .se_count_wr_in(se_count_wr_in),
    .se_setup_in(se_setup_in), .sof_in(sof_in), .nak_out(nak_out));
`default_nettype wire

// ---- verif/receive_fifo_status_flags_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module receive_fifo_status_flags_bench;
    import rfsf_pkg::*;
    logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr, err;
    logic        se_wr, se_cwr, se_setup, sof, nak, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  se_data;
    logic [9:0]  se_cnt;
    logic [31:0] lfsr = 32'h39a5_7e82;
    logic [7:0]  exp_q[$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    rfsf_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .se_wr_in(se_wr), .se_data_in(se_data),
        .se_count_wr_in(se_cwr), .se_count_in(se_cnt),
        .se_setup_in(se_setup), .sof_in(sof), .nak_out(nak), .irq_out(irq));
    rfsf_engine_model u_eng (.wr_out(se_wr), .data_out(se_data),
        .cnt_wr_out(se_cwr), .cnt_out(se_cnt), .setup_out(se_setup),
        .sof_out(sof), .clk_in(clk_in));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Watchdog; the run needs only about six hundred cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Flag word from stored level, configured size and sticky errors
    function automatic logic [31:0] flags_of(int lvl, int sz, logic u, logic o);
        return {28'h0, lvl == 0, lvl >= sz, u, o};
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [31:0] d);
        int n = 0;
        // Unused upper write data bits carry random noise
        lfsr = next_rand(lfsr);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {lfsr[31:8], d[7:0]};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) num_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk_reg(q, exp);
    endtask

    task automatic fill(input int n);
        repeat (n) begin
            lfsr = next_rand(lfsr);
            u_eng.put_byte(lfsr[7:0]);
            exp_q.push_back(lfsr[7:0]);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        rst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(IDX_FLAGS, {24'h0, FLAGS_RST});
        apb(1'b1, IDX_FLAGS, 32'hF);
        rd_chk(IDX_FLAGS, {24'h0, FLAGS_RST});
        apb(1'b0, 10'h3FF, 32'h0);
        chk_bit(err, 1'b1);
        chk_reg(q, 32'h0);
        // Full boundary for every size code; stray SETUP or SOF is harmless
        for (int sc = 0; sc < 4; sc++) begin
            apb(1'b1, IDX_CTRL, 32'(sc << CTL_SZ) | 32'h1);
            exp_q.delete();
            fill((8 << sc) - 1);
            rd_chk(IDX_FLAGS, flags_of((8 << sc) - 1, 8 << sc, 0, 0));
            fill(1);
            lfsr = next_rand(lfsr);
            u_eng.strobe(lfsr[0]);
            rd_chk(IDX_FLAGS, flags_of(8 << sc, 8 << sc, 0, 0));
        end
        // Drain eight bytes; full falls with the first pop
        apb(1'b1, IDX_CTRL, 32'h1);
        exp_q.delete();
        fill(8);
        for (int i = 8; i > 0; i--) begin
            rd_chk(IDX_DATA, {24'h0, exp_q.pop_front()});
            rd_chk(IDX_FLAGS, flags_of(i - 1, 8, 0, 0));
        end
        apb(1'b0, IDX_DATA, 32'h0);
        rd_chk(IDX_FLAGS, flags_of(0, 8, 1, 0));
        chk_bit(nak, 1'b1);
        fill(1);
        rd_chk(IDX_DATA, {24'h0, exp_q.pop_front()});
        rd_chk(IDX_FLAGS, flags_of(0, 8, 1, 0));
        apb(1'b1, IDX_CTRL, 32'h1);
        rd_chk(IDX_FLAGS, flags_of(0, 8, 0, 0));
        chk_bit(nak, 1'b0);
        rd_chk(IDX_CNTL, 32'h0);
        rd_chk(IDX_FLAGS, flags_of(0, 8, 1, 0));
        // Byte into full storage is dropped, oldest byte intact
        apb(1'b1, IDX_CTRL, 32'h1);
        fill(8);
        u_eng.put_byte(8'h5A);
        rd_chk(IDX_FLAGS, flags_of(8, 8, 0, 1));
        chk_bit(nak, 1'b1);
        rd_chk(IDX_DATA, {24'h0, exp_q.pop_front()});
        u_eng.strobe(1'b1);
        rd_chk(IDX_FLAGS, flags_of(7, 8, 0, 0));
        // Fourth data set overruns the count; random counts before it
        apb(1'b1, IDX_CTRL, 32'h1);
        exp_q.delete();
        repeat (3) begin
            lfsr = next_rand(lfsr);
            u_eng.put_count(lfsr[9:0]);
        end
        rd_chk(IDX_CNTL, {24'h0, lfsr[7:0]});
        u_eng.put_count(10'h2A5);
        rd_chk(IDX_DSCNT, 32'h3);
        rd_chk(IDX_FLAGS, flags_of(0, 8, 0, 1));
        rd_chk(IDX_CNTL, 32'hA5);
        rd_chk(IDX_CNTH, 32'h2);
        // Interrupt raised, cleared by status read, then masked
        apb(1'b1, IDX_CTRL, 32'h1);
        apb(1'b1, IDX_IMASK, 32'h3);
        apb(1'b0, IDX_ISTAT, 32'h0);
        apb(1'b0, IDX_DATA, 32'h0);
        chk_bit(irq, 1'b1);
        rd_chk(IDX_ISTAT, 32'h1);
        chk_bit(irq, 1'b0);
        apb(1'b1, IDX_IMASK, 32'h0);
        apb(1'b1, IDX_CTRL, 32'h1);
        apb(1'b0, IDX_DATA, 32'h0);
        chk_bit(irq, 1'b0);
        // Isochronous: engine overrun and set count wait for the frame start
        apb(1'b1, IDX_CTRL, 32'h5);
        fill(8);
        u_eng.put_byte(8'h3C);
        u_eng.put_count(10'h008);
        rd_chk(IDX_FLAGS, flags_of(8, 8, 0, 0));
        rd_chk(IDX_DSCNT, 32'h0);
        u_eng.strobe(1'b0);
        rd_chk(IDX_FLAGS, flags_of(8, 8, 0, 1));
        rd_chk(IDX_DSCNT, 32'h1);
        apb(1'b1, IDX_CTRL, 32'h5);
        exp_q.delete();
        u_eng.put_count(10'h001);
        u_eng.strobe(1'b0);
        apb(1'b0, IDX_DATA, 32'h0);
        rd_chk(IDX_FLAGS, flags_of(0, 8, 1, 0));
        apb(1'b1, IDX_CTRL, 32'h6);
        rd_chk(IDX_DSCNT, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
